// ---- inc/park_seq_params.svh ----
`ifndef PARK_SEQ_PARAMS_SVH
`define PARK_SEQ_PARAMS_SVH
// Clock rate of clk_sys in kHz.
`define CLK_KHZ            10000
// Period of clk_sys in ns.
`define CLK_PERIOD_NS      100
// Park warning interval in microseconds.
`define PARK_WARN_US       40
// Longest park run in cycles, rounded down from the warning interval.
`define PARK_WARN_CYC      ((`PARK_WARN_US * `CLK_KHZ) / 1000)
// Glitch filter span on the park request in ns.
`define PARK_FILT_NS       150
// Filter cycles, a least time, rounded up.
`define PARK_FILT_CYC      ((`PARK_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reference clock choice: 0 selects 16 MHz, 1 selects 24 MHz.
`define REF_SEL_16         1'h0
`define REF_SEL_24         1'h1
`endif

// ---- inc/park_seq_pkg.sv ----
package park_seq_pkg;
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_PLL_LOCK,
        ST_FLASH_LOAD,
        ST_READY,
        ST_PARKING,
        ST_PARKED
    } seq_state_t;
endpackage : park_seq_pkg

// ---- core/power_up_init_park_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "park_seq_params.svh"

// How it works
// - While held in reset, outputs sit inactive and every two-way pin is an input.
// - While held in reset, the illumination selects and flash clock, data and select float.
// - After release the block waits for PLL lock and only then loads configuration from flash.
// - On release every I/O pin is enabled.
// - Right after release the host interrupt line is driven high to show initialization runs.
// - When initialization completes the host interrupt line is driven low.
// - A low park request in the ready state parks the mirror array within the warning interval.
// - The park request is filtered so slow-edge glitches up to 150 ns are ignored.
// - The PLL accepts a 24 MHz or a 16 MHz reference clock.
module power_up_init_park_seq
#(
    parameter int FILT_CYC = `PARK_FILT_CYC,
    parameter int PARK_CYC = `PARK_WARN_CYC
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      system_hold_n,
    input  wire logic                      mirror_park_request_n,
    input  wire logic                      ref_clk_select,
    input  wire logic                      pll_locked,
    input  wire logic                      flash_load_done,
    input  wire logic                      mirror_parked,
    output logic                           pll_enable,
    output logic                           pll_ref_24mhz,
    output logic                           flash_load_start,
    output logic                           mirror_park_cmd,
    output logic                           park_timeout,
    output logic                           host_irq_out,
    output logic                           host_irq_oe,
    output logic                           io_enable,
    output logic                           illum_select_oe,
    output logic                           flash_pins_oe,
    output logic                           bidir_oe,
    output park_seq_pkg::seq_state_t       seq_state
);
    import park_seq_pkg::*;

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_t  st;
        logic        filt_level;
        logic [7:0]  filt_cnt;
        logic [15:0] park_cnt;
        logic        ref24;
        logic        load_start;
        logic        park_cmd;
        logic        timeout;
        logic        irq_out;
        logic        irq_oe;
        logic        io_en;
        logic        illum_oe;
        logic        flash_oe;
        logic        bidir;
        logic        pll_en;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Reset image: everything inactive, all pins floating or inputs.
    function automatic state_t reset_image();
        state_t r;
        r            = '0;
        r.st         = ST_HOLD;
        r.filt_level = 1'h1;
        return r;
    endfunction : reset_image

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Filter, sequencing and park control.
    always_comb
    begin
        next_cur            = cur;
        next_cur.load_start = 1'h0;
        // A new level must be seen on FILT_CYC+1 edges in a row before it is taken.
        // park request filter
        if (mirror_park_request_n == cur.filt_level)
        begin
            next_cur.filt_cnt = 8'h00;
        end
        else if (cur.filt_cnt >= 8'(FILT_CYC))
        begin
            next_cur.filt_level = mirror_park_request_n;
            next_cur.filt_cnt   = 8'h00;
        end
        else
        begin
            next_cur.filt_cnt = cur.filt_cnt + 8'h01;
        end
        // Sequencer: release, lock, load, ready and then park.
        unique case (cur.st)
            ST_HOLD:
            begin
                if (!system_hold_n)
                begin
                    next_cur = reset_image();
                end
                else
                begin
                    next_cur.io_en    = 1'h1;
                    next_cur.illum_oe = 1'h1;
                    next_cur.flash_oe = 1'h1;
                    next_cur.bidir    = 1'h1;
                    next_cur.irq_out  = 1'h1;
                    next_cur.irq_oe   = 1'h1;
                    next_cur.ref24    = ref_clk_select;
                    next_cur.pll_en   = 1'h1;
                    next_cur.st       = ST_PLL_LOCK;
                end
            end
            ST_PLL_LOCK:
            begin
                if (pll_locked)
                begin
                    next_cur.load_start = 1'h1;
                    next_cur.st         = ST_FLASH_LOAD;
                end
            end
            ST_FLASH_LOAD:
            begin
                if (flash_load_done)
                begin
                    next_cur.irq_out = 1'h0;
                    next_cur.st      = ST_READY;
                end
            end
            ST_READY:
            begin
                if (!cur.filt_level)
                begin
                    next_cur.park_cmd = 1'h1;
                    next_cur.park_cnt = 16'h0000;
                    next_cur.st       = ST_PARKING;
                end
            end
            ST_PARKING:
            begin
                if (mirror_parked)
                begin
                    next_cur.st = ST_PARKED;
                end
                else if (cur.park_cnt >= 16'(PARK_CYC - 1))
                begin
                    // The flag stays set so the host can tell that the array never confirmed.
                    next_cur.timeout = 1'h1;
                    next_cur.st      = ST_PARKED;
                end
                else
                begin
                    next_cur.park_cnt = cur.park_cnt + 16'h0001;
                end
            end
            ST_PARKED:
            begin
                // Park is terminal; only a new hold leaves this state.
                next_cur.park_cmd = 1'h1;
            end
        endcase
        if (!system_hold_n)
        begin
            next_cur = reset_image();
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // The asynchronous reset loads the hold image at once.
    // inactive outputs in reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cur <= reset_image();
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state record.
    // float selects and flash pins
    assign illum_select_oe  = cur.illum_oe;
    assign flash_pins_oe    = cur.flash_oe;
    assign bidir_oe         = cur.bidir;
    assign io_enable        = cur.io_en;
    assign host_irq_out     = cur.irq_out;
    assign host_irq_oe      = cur.irq_oe;
    assign pll_enable       = cur.pll_en;
    assign pll_ref_24mhz    = cur.ref24;
    assign flash_load_start = cur.load_start;
    assign mirror_park_cmd  = cur.park_cmd;
    assign park_timeout     = cur.timeout;
    assign seq_state        = cur.st;
endmodule : power_up_init_park_seq
`default_nettype wire

// ---- sim/power_up_init_park_seq_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Ties the sequencer's pin enables, interrupt, load start and park command to the inputs that cause them.
module park_seq_chk
    import park_seq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic system_hold_n,
    input wire logic mirror_park_request_n,
    input wire logic pll_locked,
    input wire logic flash_load_start,
    input wire logic mirror_park_cmd,
    input wire logic host_irq_out,
    input wire logic host_irq_oe,
    input wire logic io_enable,
    input wire logic illum_select_oe,
    input wire logic flash_pins_oe,
    input wire logic bidir_oe,
    input wire park_seq_pkg::seq_state_t seq_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Hold, release and initialization.
    a_hold_quiet: assert property (!system_hold_n |=> !(host_irq_oe|io_enable|illum_select_oe|flash_pins_oe|bidir_oe))
        else $error("outputs active in hold");
    a_release_drive: assert property (seq_state == ST_HOLD && system_hold_n |=> host_irq_out && host_irq_oe && io_enable)
        else $error("release did not drive pins");
    a_lock_first: assert property (flash_load_start |-> $past(pll_locked))
        else $error("load before lock");
    a_start_pulse: assert property (flash_load_start |=> !flash_load_start)
        else $error("load start too long");
    a_init_irq: assert property (seq_state inside {ST_PLL_LOCK, ST_FLASH_LOAD} |-> host_irq_out && host_irq_oe)
        else $error("irq not high during init");
    a_ready_irq: assert property (seq_state == ST_READY |-> !host_irq_out && host_irq_oe)
        else $error("irq not low when ready");
    // Filtered park request.
    a_park_filter: assert property ($rose(mirror_park_cmd) |-> !$past(mirror_park_request_n, 3))
        else $error("park on short glitch");
    a_park_prompt: assert property ((seq_state == ST_READY && !mirror_park_request_n && system_hold_n) [*3]
        |-> ##[1:3] (mirror_park_cmd || !system_hold_n))
        else $error("park not started");
    a_park_sticky: assert property (mirror_park_cmd && system_hold_n |=> mirror_park_cmd)
        else $error("park command dropped");
endmodule : park_seq_chk
bind power_up_init_park_seq park_seq_chk u_chk (.clk_sys, .rst, .system_hold_n, .mirror_park_request_n, .pll_locked,
    .flash_load_start, .mirror_park_cmd, .host_irq_out, .host_irq_oe, .io_enable, .illum_select_oe, .flash_pins_oe,
    .bidir_oe, .seq_state);
`default_nettype wire

// ---- sim/park_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// PLL, flash and mirror array; slow locks late and never confirms park.
module park_partner
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pll_enable,
    input wire logic flash_load_start,
    input wire logic mirror_park_cmd,
    input wire logic slow,
    output logic     pll_locked,
    output logic     flash_load_done,
    output logic     mirror_parked
);
    logic [3:0] cnt;
    // One delay counter, restarted by each load request.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst || !pll_enable || flash_load_start) cnt <= 4'h0;
        else if (cnt != 4'hF) cnt <= cnt + 4'h1;
        if (rst) pll_locked <= 1'h0;
        else pll_locked <= pll_enable && (pll_locked || cnt == (slow ? 4'h8 : 4'h2));
        mirror_parked <= !rst && mirror_park_cmd && !slow;
    end
    // Load finishes only once the lock is up.
    assign flash_load_done = pll_locked && cnt == 4'h3;
endmodule : park_partner
`default_nettype wire

// ---- sim/power_up_init_park_seq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "park_seq_params.svh"
module power_up_init_park_seq_tb;
    import park_seq_pkg::*;
    logic clk_sys = 1'h0, rst = 1'h1, system_hold_n = 1'h0, mirror_park_request_n = 1'h1, ref_clk_select = 1'h1;
    logic slow = 1'h0, pll_locked, flash_load_done, mirror_parked, pll_enable, pll_ref_24mhz, flash_load_start;
    logic mirror_park_cmd, park_timeout, host_irq_out, host_irq_oe, io_enable, illum_select_oe, flash_pins_oe, bidir_oe;
    seq_state_t seq_state;
    int failures = 0;
    int samples_checked = 0;
    // Clock at 10 MHz.
    always #(`CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    power_up_init_park_seq #(.PARK_CYC(20)) u_power_up_init_park_seq (.clk_sys, .rst, .system_hold_n,
        .mirror_park_request_n, .ref_clk_select, .pll_locked, .flash_load_done, .mirror_parked, .pll_enable,
        .pll_ref_24mhz, .flash_load_start, .mirror_park_cmd, .park_timeout, .host_irq_out, .host_irq_oe, .io_enable,
        .illum_select_oe, .flash_pins_oe, .bidir_oe, .seq_state);
    park_partner u_park_partner (.clk_sys, .rst, .pll_enable, .flash_load_start, .mirror_park_cmd, .slow,
        .pll_locked, .flash_load_done, .mirror_parked);
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : step
    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic t_init(input logic r, input logic s);
        int n = 0;
        logic [2:0] starts = 3'h0;
        ref_clk_select = r;
        slow = s;
        system_hold_n = 1'h1;
        step(1);
        check("irq drive", {host_irq_out, host_irq_oe, io_enable}, 3'h7);
        check("pins on", {bidir_oe, illum_select_oe, flash_pins_oe}, 3'h7);
        check("pll on", pll_enable, 1'h1);
        check("ref", pll_ref_24mhz, r);
        step(3);
        check("lock wait", seq_state, ST_PLL_LOCK);
        while (!(host_irq_oe === 1'h1 && host_irq_out === 1'h0) && n < 40)
        begin
            step(1);
            n++;
            if (flash_load_start === 1'h1)
            begin
                starts++;
                check("lock first", pll_locked, 1'h1);
            end
        end
        check("one load", starts, 3'h1);
        check("done", {host_irq_out, host_irq_oe, pll_locked}, 3'h3);
        check("ready", seq_state, ST_READY);
    endtask : t_init
    task automatic t_park(input logic ok);
        mirror_park_request_n = 1'h0;
        step(2);
        mirror_park_request_n = 1'h1;
        step(6);
        check("glitch", mirror_park_cmd, 1'h0);
        mirror_park_request_n = 1'h0;
        step(3);
        check("filter", mirror_park_cmd, 1'h0);
        step(1);
        check("park", mirror_park_cmd, 1'h1);
        step(25);
        check("parked", {mirror_parked, park_timeout}, {ok, !ok});
        step(`PARK_WARN_CYC);
    endtask : t_park
    task automatic t_hold(input int n);
        system_hold_n = 1'h0;
        mirror_park_request_n = 1'h1;
        step(n);
        check("hold oe", {host_irq_oe, illum_select_oe, flash_pins_oe}, 3'h0);
        check("hold io", {io_enable, bidir_oe, mirror_park_cmd}, 3'h0);
        check("hold pll", {pll_enable, park_timeout, host_irq_out}, 3'h0);
    endtask : t_hold
    task automatic results;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // Main sequence; the bench acts as power monitor and keeps the clock running.
    initial
    begin
        step(16);
        rst = 1'h0;
        t_hold(2);
        t_init(`REF_SEL_24, 1'h0);
        t_park(1'h1);
        t_hold(2);
        slow = 1'h1;
        system_hold_n = 1'h1;
        step(3);
        check("mid init", seq_state, ST_PLL_LOCK);
        t_hold(2);
        t_init(`REF_SEL_16, 1'h1);
        t_park(1'h0);
        results;
    end
    // Watchdog, well beyond the roughly 1000 cycles that the scenarios take.
    initial
    begin
        #(`CLK_PERIOD_NS * 2000);
        failures++;
        results;
    end
endmodule : power_up_init_park_seq_tb
`default_nettype wire
